// ==== design/lstr_sensor_readout.v ====
// serial-bus register target, result capture and interrupt of the sensor
`include "lstr_regs.vh"

module lstr_sensor_readout #(
    parameter DATA_W = 16,
    parameter CYC_W  = 16
) (
    input  wire              clk_sys,
    input  wire              rst_b,
    input  wire              scl_in,
    input  wire              sda_in,
    output wire              sda_out,
    output wire              sda_oe_n,
    output wire              int_out,
    output wire              int_oe_n,
    input  wire              conv_done,
    input  wire [DATA_W-1:0] conv_data,
    input  wire              osc_tick,
    input  wire              ext_timing,
    input  wire [1:0]        width_sel,
    output reg  [1:0]        range_sel,
    output reg  [17:0]       full_scale_span,
    output reg  [15:0]       full_scale_count,
    output reg               timer_valid,
    output reg               sync_req
);

    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_WR   = 3'd3;
    localparam ST_WACK = 3'd4;
    localparam ST_RD   = 3'd5;
    localparam ST_RACK = 3'd6;

    // pin synchronisers and filtered levels
    reg [2:0] scl_sync_reg;
    reg [2:0] sda_sync_reg;
    reg       scl_filt_reg;
    reg       sda_filt_reg;
    wire      scl_rise;
    wire      scl_fall;
    wire      bus_start;
    wire      bus_stop;

    // serial engine state
    reg [2:0]            state_reg;
    reg [3:0]            bit_cnt_reg;
    reg [7:0]            shift_reg;
    reg                  rw_reg;
    reg                  first_reg;
    reg                  drive_low_reg;
    reg [`LSTR_PTR_W-1:0] ptr_reg;

    // register file
    reg [7:0]        ctrl_reg;
    reg [7:0]        uthr_reg;
    reg [7:0]        lthr_reg;
    reg [DATA_W-1:0] result_reg;
    reg [CYC_W-1:0]  cyc_cnt_reg;
    reg [CYC_W-1:0]  cyc_cap_reg;
    reg              flag_reg;
    reg [7:0]        ctrl_reg_view;

    reg              wr_ctrl;
    reg              clr_cmd;
    wire             trigger;
    wire [7:0]       rd_byte;

    function [7:0] read_mux;
        input [`LSTR_PTR_W-1:0] a;
        input [7:0]             ctrl_v;
        input [7:0]             uthr_v;
        input [7:0]             lthr_v;
        input [DATA_W-1:0]      res_v;
        input [CYC_W-1:0]       cyc_v;
        begin
            if (a == `LSTR_OFF_CTRL)
                read_mux = ctrl_v;
            else if (a == `LSTR_OFF_UTHR)
                read_mux = uthr_v;
            else if (a == `LSTR_OFF_LTHR)
                read_mux = lthr_v;
            else if (a == `LSTR_OFF_RES_LO)
                read_mux = res_v[7:0];
            else if (a == `LSTR_OFF_RES_HI)
                read_mux = res_v[15:8];
            else if (a == `LSTR_OFF_CYC_LO)
                read_mux = cyc_v[7:0];
            else if (a == `LSTR_OFF_CYC_HI)
                read_mux = cyc_v[15:8];
            else
                read_mux = 8'h00;
        end
    endfunction

    // a level change counts once the second and third stages agree
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            scl_sync_reg <= 3'b111;
            sda_sync_reg <= 3'b111;
            scl_filt_reg <= 1'b1;
            sda_filt_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_filt_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_filt_reg <= sda_sync_reg[2];
        end
    end

    wire scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ?
                    scl_sync_reg[2] : scl_filt_reg;
    wire sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ?
                    sda_sync_reg[2] : sda_filt_reg;

    assign scl_rise  = !scl_filt_reg && scl_next;
    assign scl_fall  = scl_filt_reg && !scl_next;
    assign bus_start = scl_filt_reg && scl_next && sda_filt_reg && !sda_next;
    assign bus_stop  = scl_filt_reg && scl_next && !sda_filt_reg && sda_next;

    assign rd_byte = read_mux(ptr_reg, ctrl_reg_view, uthr_reg, lthr_reg,
                              result_reg, cyc_cap_reg);

    // open-drain data line: only ever pulled low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !drive_low_reg;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            rw_reg        <= 1'b0;
            first_reg     <= 1'b0;
            drive_low_reg <= 1'b0;
            ptr_reg       <= {`LSTR_PTR_W{1'b0}};
            wr_ctrl       <= 1'b0;
            clr_cmd       <= 1'b0;
            sync_req      <= 1'b0;
        end else begin
            wr_ctrl  <= 1'b0;
            clr_cmd  <= 1'b0;
            sync_req <= 1'b0;
            if (bus_start) begin
                state_reg     <= ST_ADDR;
                bit_cnt_reg   <= 4'h0;
                drive_low_reg <= 1'b0;
            end else if (bus_stop) begin
                state_reg     <= ST_IDLE;
                drive_low_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_next};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (shift_reg[7:1] == `LSTR_TARGET_ADDR) begin
                                rw_reg        <= shift_reg[0];
                                drive_low_reg <= 1'b1;
                                state_reg     <= ST_AACK;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            first_reg   <= 1'b1;
                            if (rw_reg) begin
                                shift_reg     <= rd_byte;
                                drive_low_reg <= !rd_byte[7];
                                state_reg     <= ST_RD;
                            end else begin
                                drive_low_reg <= 1'b0;
                                state_reg     <= ST_WR;
                            end
                        end
                    end
                    ST_WR: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_next};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            drive_low_reg <= 1'b1;
                            state_reg     <= ST_WACK;
                            if (first_reg) begin
                                // command byte: pointer plus action bits
                                ptr_reg  <= shift_reg[`LSTR_PTR_W-1:0];
                                clr_cmd  <= shift_reg[`LSTR_CMD_CLR_BIT];
                                sync_req <= shift_reg[`LSTR_CMD_SYNC_BIT];
                            end else begin
                                wr_ctrl <= 1'b1;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            drive_low_reg <= 1'b0;
                            bit_cnt_reg   <= 4'h0;
                            state_reg     <= ST_WR;
                            if (!first_reg)
                                ptr_reg <= ptr_reg + 1'b1;
                            first_reg <= 1'b0;
                        end
                    end
                    ST_RD: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                drive_low_reg <= 1'b0;
                                state_reg     <= ST_RACK;
                            end else begin
                                shift_reg     <= {shift_reg[6:0], 1'b0};
                                drive_low_reg <= !shift_reg[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_next) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                ptr_reg <= ptr_reg + 1'b1;
                            end
                        end else if (scl_fall) begin
                            shift_reg     <= rd_byte;
                            drive_low_reg <= !rd_byte[7];
                            bit_cnt_reg   <= 4'h0;
                            state_reg     <= ST_RD;
                        end
                    end
                    default: begin
                        drive_low_reg <= 1'b0;
                        state_reg     <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // register writes; the data byte sits in shift_reg while wr_ctrl pulses
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_reg <= `LSTR_CTRL_RST;
            uthr_reg <= `LSTR_UTHR_RST;
            lthr_reg <= `LSTR_LTHR_RST;
        end else if (wr_ctrl) begin
            if (ptr_reg == `LSTR_OFF_CTRL)
                ctrl_reg <= {4'h0, shift_reg[3:0]};
            else if (ptr_reg == `LSTR_OFF_UTHR)
                uthr_reg <= shift_reg;
            else if (ptr_reg == `LSTR_OFF_LTHR)
                lthr_reg <= shift_reg;
        end
    end

    // interrupt flag: a trigger in the clearing cycle wins
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            flag_reg <= 1'b0;
        end else if (trigger) begin
            flag_reg <= 1'b1;
        end else if (clr_cmd) begin
            flag_reg <= 1'b0;
        end else if (wr_ctrl && ptr_reg == `LSTR_OFF_CTRL &&
                     !shift_reg[`LSTR_CTRL_FLAG_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    // pin pulled low while the flag stands, released otherwise
    assign int_out  = 1'b0;
    assign int_oe_n = !flag_reg;

    // conversion result and cycle count capture
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            result_reg  <= {DATA_W{1'b0}};
            cyc_cnt_reg <= {CYC_W{1'b0}};
            cyc_cap_reg <= {CYC_W{1'b0}};
        end else if (conv_done) begin
            result_reg  <= conv_data;
            cyc_cap_reg <= cyc_cnt_reg + {{(CYC_W-1){1'b0}}, osc_tick};
            cyc_cnt_reg <= {CYC_W{1'b0}};
        end else if (osc_tick) begin
            cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
        end
    end

    // range and full-scale reporting
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            range_sel        <= 2'b00;
            full_scale_span  <= `LSTR_SPAN_R1;
            full_scale_count <= `LSTR_FS_W0;
            timer_valid      <= 1'b0;
        end else begin
            range_sel   <= ctrl_reg[`LSTR_CTRL_RNG_HI:`LSTR_CTRL_RNG_LO];
            timer_valid <= ext_timing;
            case (ctrl_reg[`LSTR_CTRL_RNG_HI:`LSTR_CTRL_RNG_LO])
                2'b00:   full_scale_span <= `LSTR_SPAN_R1;
                2'b01:   full_scale_span <= `LSTR_SPAN_R2;
                2'b10:   full_scale_span <= `LSTR_SPAN_R3;
                default: full_scale_span <= `LSTR_SPAN_R4;
            endcase
            case (width_sel)
                2'b00:   full_scale_count <= `LSTR_FS_W0;
                2'b01:   full_scale_count <= `LSTR_FS_W1;
                2'b10:   full_scale_count <= `LSTR_FS_W2;
                default: full_scale_count <= `LSTR_FS_W3;
            endcase
        end
    end

    // control readback shows the live flag in bit 5
    always @* begin
        ctrl_reg_view = ctrl_reg;
        ctrl_reg_view[`LSTR_CTRL_FLAG_BIT] = flag_reg;
    end

    lstr_window_persist #(
        .DATA_W (DATA_W),
        .CNT_W  (5)
    ) u_window (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .conv_done   (conv_done),
        .conv_data   (conv_data),
        .upper_thr   (uthr_reg),
        .lower_thr   (lthr_reg),
        .persist_sel (ctrl_reg[`LSTR_CTRL_PER_HI:`LSTR_CTRL_PER_LO]),
        .trigger     (trigger)
    );

endmodule // lstr_sensor_readout

// ==== design/lstr_regs.vh ====
// register map, field positions and reset values of the light threshold block
`ifndef LSTR_REGS_VH
`define LSTR_REGS_VH

`define LSTR_TARGET_ADDR   7'h44
`define LSTR_PTR_W         6

`define LSTR_OFF_CTRL      6'h01
`define LSTR_OFF_UTHR      6'h02
`define LSTR_OFF_LTHR      6'h03
`define LSTR_OFF_RES_LO    6'h04
`define LSTR_OFF_RES_HI    6'h05
`define LSTR_OFF_CYC_LO    6'h06
`define LSTR_OFF_CYC_HI    6'h07

`define LSTR_CTRL_FLAG_BIT 5
`define LSTR_CTRL_RNG_HI   3
`define LSTR_CTRL_RNG_LO   2
`define LSTR_CTRL_PER_HI   1
`define LSTR_CTRL_PER_LO   0

`define LSTR_CMD_SYNC_BIT  7
`define LSTR_CMD_CLR_BIT   6

`define LSTR_CTRL_RST      8'h00
`define LSTR_UTHR_RST      8'hff
`define LSTR_LTHR_RST      8'h00
`define LSTR_THR_LSB       8'h00

`define LSTR_PERSIST_C0    5'h01
`define LSTR_PERSIST_C1    5'h04
`define LSTR_PERSIST_C2    5'h08
`define LSTR_PERSIST_C3    5'h10

`define LSTR_SPAN_R1       18'h0_07d0
`define LSTR_SPAN_R2       18'h0_1f40
`define LSTR_SPAN_R3       18'h0_7d00
`define LSTR_SPAN_R4       18'h1_f400

`define LSTR_FS_W0         16'h8000
`define LSTR_FS_W1         16'h0800
`define LSTR_FS_W2         16'h0080
`define LSTR_FS_W3         16'h0008

`endif

// ==== design/lstr_window_persist.v ====
// threshold window compare and persistence counter
`include "lstr_regs.vh"

module lstr_window_persist #(
    parameter DATA_W = 16,
    parameter CNT_W  = 5
) (
    input  wire              clk_sys,
    input  wire              rst_b,
    input  wire              conv_done,
    input  wire [DATA_W-1:0] conv_data,
    input  wire [7:0]        upper_thr,
    input  wire [7:0]        lower_thr,
    input  wire [1:0]        persist_sel,
    output reg               trigger
);

    reg  [CNT_W-1:0] run_reg;
    wire [CNT_W-1:0] need;
    wire [CNT_W-1:0] run_inc;
    wire             out_of_window;

    function [CNT_W-1:0] persist_count;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   persist_count = `LSTR_PERSIST_C0;
                2'b01:   persist_count = `LSTR_PERSIST_C1;
                2'b10:   persist_count = `LSTR_PERSIST_C2;
                default: persist_count = `LSTR_PERSIST_C3;
            endcase
        end
    endfunction

    assign need    = persist_count(persist_sel);
    assign run_inc = run_reg + 1'b1;
    assign out_of_window = (conv_data > {upper_thr, `LSTR_THR_LSB}) ||
                           (conv_data < {lower_thr, `LSTR_THR_LSB});

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            run_reg <= {CNT_W{1'b0}};
            trigger <= 1'b0;
        end else begin
            trigger <= 1'b0;
            if (conv_done) begin
                if (out_of_window) begin
                    if (run_inc >= need) begin
                        trigger <= 1'b1;
                        run_reg <= need;
                    end else begin
                        run_reg <= run_inc;
                    end
                end else begin
                    run_reg <= {CNT_W{1'b0}};
                end
            end
        end
    end

endmodule // lstr_window_persist

// ==== verif/lstr_readout_properties.sv ====
// pin-level checks of the sensor readout block
module lstr_readout_properties (
    input wire        clk_sys,
    input wire        rst_b,
    input wire        scl_in,
    input wire        sda_out,
    input wire        sda_oe_n,
    input wire        int_out,
    input wire        int_oe_n,
    input wire        conv_done,
    input wire        ext_timing,
    input wire [1:0]  width_sel,
    input wire [1:0]  range_sel,
    input wire [17:0] full_scale_span,
    input wire [15:0] full_scale_count,
    input wire        timer_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_span_map: assert property (
        $stable(range_sel) |->
        full_scale_span == (18'h0_07d0 << {range_sel, 1'b0}))
        else $error("span does not match range code");
    a_count_map: assert property (
        $past(rst_b) |->
        full_scale_count == (16'h8000 >> {$past(width_sel), 2'b00}))
        else $error("full scale count does not match width code");
    a_timer_mode: assert property (
        $past(rst_b) |-> timer_valid == $past(ext_timing))
        else $error("timer valid does not follow timing mode");
    a_int_after_conv: assert property (
        $fell(int_oe_n) |-> $past(conv_done, 2))
        else $error("interrupt asserted without a conversion");
    a_int_pin_low: assert property (
        int_out == 1'b0)
        else $error("interrupt pin drives high");
    a_sda_pin_low: assert property (
        sda_out == 1'b0)
        else $error("data pin drives high");
    a_sda_low_phase: assert property (
        $changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
        else $error("data changed while clock high");
    a_sda_holds: assert property (
        $fell(sda_oe_n) |=> sda_oe_n == 1'b0 [*8])
        else $error("driven low bit too short");

    c_int: cover property ($fell(int_oe_n));
    c_ack: cover property ($fell(sda_oe_n));
    c_range: cover property (range_sel == 2'h3);
endmodule // lstr_readout_properties

bind lstr_sensor_readout lstr_readout_properties u_lstr_readout_properties (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .conv_done(conv_done), .ext_timing(ext_timing), .width_sel(width_sel),
    .range_sel(range_sel), .full_scale_span(full_scale_span),
    .full_scale_count(full_scale_count), .timer_valid(timer_valid));

// ==== verif/lstr_host_model.sv ====
// serial bus host model, drives the clock, open drain on data
module lstr_host_model (
    input  wire        clk_sys,
    input  wire        sda_in,
    output logic       scl_o,
    output logic       sda_o,
    output logic       rd_strobe,
    output logic [7:0] rd_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rd_strobe = 1'b0;
        rd_byte = 8'h00;
    end
    task automatic ph;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic start;
        ph;
        sda_o <= 1'b0;
        ph;
        scl_o <= 1'b0;
    endtask
    task automatic stop;
        ph;
        sda_o <= 1'b0;
        ph;
        scl_o <= 1'b1;
        ph;
        sda_o <= 1'b1;
        ph;
    endtask
    // one clock: data set mid low phase, sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        ph;
        sda_o <= b;
        ph;
        scl_o <= 1'b1;
        ph;
        s = sda_in;
        ph;
        scl_o <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask
    task automatic rbyte(input logic last);
        logic [7:0] b;
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        rd_byte <= b;
        rd_strobe <= 1'b1;
        @(posedge clk_sys);
        rd_strobe <= 1'b0;
        clk_bit(last, s);
    endtask
endmodule // lstr_host_model

// ==== verif/testbench.sv ====
// self-checking bench of the sensor readout block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        conv_done = 1'b0;
    logic [15:0] conv_data = 16'h0000;
    logic        osc_tick = 1'b0;
    logic        ext_timing = 1'b0;
    logic [1:0]  width_sel = 2'h0;
    wire         scl_o, sda_o, sda_out, sda_oe_n, int_out, int_oe_n;
    wire         rd_strobe, timer_valid, sync_req;
    wire [7:0]   rd_byte;
    wire [1:0]   range_sel;
    wire [17:0]  full_scale_span;
    wire [15:0]  full_scale_count;
    wire         sda_line = sda_o & (sda_oe_n | sda_out);
    int          bad_count = 0;
    int          checked = 0;
    int          sync_seen = 0;
    int          seed = 32'h38a9;
    logic [7:0]  exp_q[$];
    logic [15:0] cnt_exp, data_exp;

    always #5 clk_sys = ~clk_sys;

    lstr_sensor_readout u_lstr_sensor_readout (
        .clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_o), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out),
        .int_oe_n(int_oe_n), .conv_done(conv_done), .conv_data(conv_data),
        .osc_tick(osc_tick), .ext_timing(ext_timing), .width_sel(width_sel),
        .range_sel(range_sel), .full_scale_span(full_scale_span),
        .full_scale_count(full_scale_count), .timer_valid(timer_valid),
        .sync_req(sync_req));
    lstr_host_model u_lstr_host_model (
        .clk_sys(clk_sys), .sda_in(sda_line), .scl_o(scl_o), .sda_o(sda_o),
        .rd_strobe(rd_strobe), .rd_byte(rd_byte));

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic put(input logic [7:0] d);
        logic ack;
        u_lstr_host_model.wbyte(d, ack);
        check(ack, 1'b0);
    endtask
    task automatic wreg(input logic [7:0] cmd, input logic [7:0] d,
                        input bit has_d);
        u_lstr_host_model.start;
        put(8'h88);
        put(cmd);
        if (has_d) put(d);
        u_lstr_host_model.stop;
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        wreg(ptr, 8'h00, 0);
        u_lstr_host_model.start;
        put(8'h89);
        for (int i = 0; i < n; i++) u_lstr_host_model.rbyte(i == n - 1);
        u_lstr_host_model.stop;
    endtask
    // oscillator ticks then one conversion; ticks never meet conv_done
    task automatic conv(input logic [15:0] d);
        int k;
        k = 1 + ($random(seed) & 15);
        for (int i = 0; i < k; i++) begin
            osc_tick <= 1'b1;
            @(posedge clk_sys);
            osc_tick <= 1'b0;
            @(posedge clk_sys);
        end
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cnt_exp = k[15:0];
        data_exp = d;
    endtask
    // window is 1000h..4000h with thresholds 10h and 40h
    function automatic logic [15:0] outside();
        int r;
        r = $random(seed);
        return r[0] ? 16'h4001 + {2'b00, r[13:0]} : {4'h0, r[15:4]};
    endfunction

    always @(posedge clk_sys) begin
        if (rd_strobe === 1'b1) check(rd_byte, exp_q.pop_front());
        if (sync_req === 1'b1) sync_seen++;
    end

    initial begin
        int m;
        logic [7:0] ctrl;
        logic ack;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(full_scale_span, 18'h0_07d0);
        wreg(8'h04, 8'h5a, 1);
        exp_q = {8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        rd(8'h00, 9);
        for (int w = 0; w < 4; w++) begin
            width_sel <= w[1:0];
            ext_timing <= w[0];
            repeat (2) @(posedge clk_sys);
            check(full_scale_count, 16'h8000 >> (4 * w));
            check(timer_valid, w[0]);
        end
        wreg(8'h02, 8'h40, 1);
        wreg(8'h03, 8'h10, 1);
        for (int p = 0; p < 4; p++) begin
            m = (p == 0) ? 1 : 4 << (p - 1);
            ctrl = {4'h0, p[1:0], p[1:0]};
            wreg(8'h01, ctrl, 1);
            check(range_sel, p[1:0]);
            check(full_scale_span, 18'h0_07d0 << (2 * p));
            // restart the run left saturated by the previous code
            conv(16'h2000);
            for (int i = 1; i < m; i++) conv(outside());
            conv(16'h2000);
            for (int i = 1; i < m; i++) conv(outside());
            check(int_oe_n, 1'b1);
            conv(outside());
            check(int_oe_n, 1'b0);
            exp_q.push_back(ctrl | 8'h20);
            rd(8'h01, 1);
            exp_q = {exp_q, data_exp[7:0], data_exp[15:8],
                     cnt_exp[7:0], cnt_exp[15:8]};
            rd(8'h04, 4);
            // odd codes clear through the command byte, with a sync pulse
            if (p[0]) wreg(8'hc1, 8'h00, 0);
            else wreg(8'h01, ctrl, 1);
            check(int_oe_n, 1'b1);
            exp_q.push_back(ctrl);
            rd(8'h01, 1);
        end
        u_lstr_host_model.start;
        u_lstr_host_model.wbyte(8'h8a, ack);
        check(ack, 1'b1);
        u_lstr_host_model.stop;
        check(sync_seen, 2);
        summarize;
    end

    initial begin
        repeat (80000) @(posedge clk_sys);
        bad_count++;
        summarize;
    end
endmodule // testbench
